//--- axis_fault_pkg.sv
// Constants and carrier types for the per-axis operation fault monitor.
// Assumes a single clock domain; pin inputs are synchronised in the monitor.
// Function
// RULE1: Codes are 00F0 upper with 3xxx lower.
// RULE2: Start refused without servo lock, code 3000.
// RULE3: Servo loss during motion flags 3001.
// RULE4: Servo-on with main power off flags 3005.
// RULE5: Plus hardware limit active flags 3010.
// RULE6: Minus hardware limit active flags 3011.
// RULE7: Both limits together flag 3012 instead.
// RULE8: Position above upper soft limit flags 3020.
// RULE9: Position below lower soft limit flags 3021.
// RULE10: Command speed overflow flags 3025.
// RULE11: Internal failure 3030; abnormal end 3031, axis or all.
// RULE12: Axis group change in motion/stop or range flags 3032.
// RULE13: Interpolation partner fault stops axis, flags 3033.
// RULE14: Travel amount out of bounds flags 3035.
// RULE15: Sync group change, range or home failure flag 3040.
// RULE16: Sync partner fault stops axis, flags 3043.
// RULE17: Deviation over threshold with check on flags 3046.
// RULE18: Torque over judgement value flags 3050.
// RULE19: Actual speed over judgement value flags 3051.
// RULE20: Home return not executable flags 3060.
// RULE21: All these errors clear without power cycle.
// RULE22: Host changes sync group only when idle.
// RULE23: Code holds until clear, then goes zero; a cause detected in the clear cycle loads its code instead.
package axis_fault_pkg;
  localparam logic [15:0] code_upper         = 16'h00F0;
  localparam logic [15:0] code_none          = 16'h0000;
  localparam logic [15:0] code_not_ready     = 16'h3000;
  localparam logic [15:0] code_servo_lost    = 16'h3001;
  localparam logic [15:0] code_main_power    = 16'h3005;
  localparam logic [15:0] code_limit_plus    = 16'h3010;
  localparam logic [15:0] code_limit_minus   = 16'h3011;
  localparam logic [15:0] code_limit_both    = 16'h3012;
  localparam logic [15:0] code_soft_upper    = 16'h3020;
  localparam logic [15:0] code_soft_lower    = 16'h3021;
  localparam logic [15:0] code_speed_ovf     = 16'h3025;
  localparam logic [15:0] code_axis_fail     = 16'h3030;
  localparam logic [15:0] code_abnormal_end  = 16'h3031;
  localparam logic [15:0] code_group_change  = 16'h3032;
  localparam logic [15:0] code_interp_abort  = 16'h3033;
  localparam logic [15:0] code_travel_range  = 16'h3035;
  localparam logic [15:0] code_sync_group    = 16'h3040;
  localparam logic [15:0] code_sync_abort    = 16'h3043;
  localparam logic [15:0] code_deviation     = 16'h3046;
  localparam logic [15:0] code_torque        = 16'h3050;
  localparam logic [15:0] code_actual_speed  = 16'h3051;
  localparam logic [15:0] code_home_fail     = 16'h3060;
  localparam logic [31:0] full_code_reset    = 32'h0000_0000;
  localparam int          sync_stages        = 3;

  // Per-axis status and event inputs from the motion core and amplifier
  typedef struct packed {
    logic servo_locked;
    logic busy;
    logic interp_active;
    logic sync_active;
    logic stop_request;
    logic start_request;
    logic servo_on_request;
    logic main_power_on;
    logic speed_overflow;
    logic internal_failure;
    logic abnormal_end;
    logic group_change;
    logic group_range_bad;
    logic travel_range_bad;
    logic sync_group_change;
    logic sync_range_bad;
    logic sync_home_fail;
    logic move_check_on;
    logic home_not_executable;
  } axis_event_type;

  // Per-axis measured and configured values
  typedef struct packed {
    logic signed [31:0] position;
    logic signed [31:0] soft_upper;
    logic signed [31:0] soft_lower;
    logic [31:0]        deviation;
    logic [31:0]        deviation_limit;
    logic [15:0]        torque;
    logic [15:0]        torque_limit;
    logic [31:0]        actual_speed;
    logic [31:0]        speed_limit;
  } axis_value_type;
endpackage

//--- axis_fault_channel.sv
// One axis: picks the detected condition and latches its code.
// Assumes limit inputs already synchronised and values on the unit clock.
module axis_fault_channel (
  input  wire logic                           clk,
  input  wire logic                           rstn,
  input  wire axis_fault_pkg::axis_event_type ev,
  input  wire axis_fault_pkg::axis_value_type val,
  input  wire logic                           limit_plus,
  input  wire logic                           limit_minus,
  input  wire logic                           servo_lock_prev,
  input  wire logic                           limit_plus_prev,
  input  wire logic                           limit_minus_prev,
  input  wire logic                           interp_partner_fault,
  input  wire logic                           sync_partner_fault,
  input  wire logic                           all_abnormal_end,
  input  wire logic                           clear,
  output logic [15:0]                         code,
  output logic                                stop_axis
);
  logic [15:0] detect_code;
  logic        detect;
  wire         limit_both = limit_plus & limit_minus;
  wire         plus_rise  = limit_plus & ~limit_plus_prev;
  wire         minus_rise = limit_minus & ~limit_minus_prev;
  wire         both_rise  = limit_both & ~(limit_plus_prev & limit_minus_prev);

  // Priority select; earlier entries win when several fire together
  always_comb begin
    detect      = 1'b1;
    detect_code = axis_fault_pkg::code_none;
    if (ev.start_request && !ev.servo_locked)
      detect_code = axis_fault_pkg::code_not_ready; // RULE2
    else if (servo_lock_prev && !ev.servo_locked && ev.busy)
      detect_code = axis_fault_pkg::code_servo_lost; // RULE3
    else if (ev.servo_on_request && !ev.main_power_on)
      detect_code = axis_fault_pkg::code_main_power; // RULE4
    else if (both_rise)
      detect_code = axis_fault_pkg::code_limit_both; // RULE7
    else if (plus_rise && !limit_minus)
      detect_code = axis_fault_pkg::code_limit_plus; // RULE5
    else if (minus_rise && !limit_plus)
      detect_code = axis_fault_pkg::code_limit_minus; // RULE6
    else if (val.position > val.soft_upper)
      detect_code = axis_fault_pkg::code_soft_upper; // RULE8
    else if (val.position < val.soft_lower)
      detect_code = axis_fault_pkg::code_soft_lower; // RULE9
    else if (ev.speed_overflow)
      detect_code = axis_fault_pkg::code_speed_ovf; // RULE10
    else if (ev.internal_failure)
      detect_code = axis_fault_pkg::code_axis_fail; // RULE11
    else if (ev.abnormal_end || all_abnormal_end)
      detect_code = axis_fault_pkg::code_abnormal_end; // RULE11
    else if ((ev.group_change && (ev.busy || ev.stop_request))
             || ev.group_range_bad)
      detect_code = axis_fault_pkg::code_group_change; // RULE12
    else if (ev.interp_active && interp_partner_fault)
      detect_code = axis_fault_pkg::code_interp_abort; // RULE13
    else if (ev.travel_range_bad)
      detect_code = axis_fault_pkg::code_travel_range; // RULE14
    else if ((ev.sync_group_change && (ev.sync_active || ev.stop_request))
             || ev.sync_range_bad || ev.sync_home_fail)
      detect_code = axis_fault_pkg::code_sync_group; // RULE15
    else if (ev.sync_active && sync_partner_fault)
      detect_code = axis_fault_pkg::code_sync_abort; // RULE16
    else if (ev.move_check_on && (val.deviation > val.deviation_limit))
      detect_code = axis_fault_pkg::code_deviation; // RULE17
    else if (val.torque > val.torque_limit)
      detect_code = axis_fault_pkg::code_torque; // RULE18
    else if (val.actual_speed > val.speed_limit)
      detect_code = axis_fault_pkg::code_actual_speed; // RULE19
    else if (ev.home_not_executable)
      detect_code = axis_fault_pkg::code_home_fail; // RULE20
    else
      detect = 1'b0;
  end

  wire   holding   = (code != axis_fault_pkg::code_none);
  wire   load_code = detect && (!holding || clear);

  // First code is held; a new event in the clear cycle wins over the clear
  always_ff @(posedge clk) begin
    if (!rstn) begin
      code      <= axis_fault_pkg::code_none;
      stop_axis <= 1'b0;
    end else if (load_code) begin
      code      <= detect_code; // RULE23
      stop_axis <= 1'b1; // RULE13 RULE16
    end else if (clear) begin
      code      <= axis_fault_pkg::code_none; // RULE21 RULE23
      stop_axis <= 1'b0;
    end
  end
endmodule

//--- axis_fault_monitor.sv
// Top of the per-axis operation fault monitor: pin synchronisers,
// partner fault gathering, one channel per axis and full code outputs.
// Assumes the host keeps group changes to idle axes; limit pins async.
module axis_fault_monitor #(
  parameter int axes = 16
) (
  input  wire logic                           clk,
  input  wire logic                           rstn,
  input  wire axis_fault_pkg::axis_event_type ev [axes],
  input  wire axis_fault_pkg::axis_value_type val [axes],
  input  wire logic [axes-1:0]                limit_plus_pin,
  input  wire logic [axes-1:0]                limit_minus_pin,
  input  wire logic [axes-1:0]                interp_member,
  input  wire logic [axes-1:0]                sync_member,
  input  wire logic                           all_abnormal_end,
  input  wire logic [axes-1:0]                error_clear,
  output logic [31:0]                         error_code [axes],
  output logic [axes-1:0]                     error_present,
  output logic [axes-1:0]                     stop_request_out
);
  // Three-stage synchronisers for the limit pins
  logic [axes-1:0] plus_s1;
  logic [axes-1:0] plus_s2;
  logic [axes-1:0] plus_s3;
  logic [axes-1:0] minus_s1;
  logic [axes-1:0] minus_s2;
  logic [axes-1:0] minus_s3;
  logic [axes-1:0] plus_level;
  logic [axes-1:0] minus_level;
  logic [axes-1:0] plus_prev;
  logic [axes-1:0] minus_prev;
  logic [axes-1:0] lock_prev;
  logic [axes-1:0] chan_stop;
  logic [15:0]     chan_code [axes];
  logic [axes-1:0] faulted;

  always_ff @(posedge clk) begin
    if (!rstn) begin
      plus_s1  <= '0;
      plus_s2  <= '0;
      plus_s3  <= '0;
      minus_s1 <= '0;
      minus_s2 <= '0;
      minus_s3 <= '0;
    end else begin
      plus_s1  <= limit_plus_pin;
      plus_s2  <= plus_s1;
      plus_s3  <= plus_s2;
      minus_s1 <= limit_minus_pin;
      minus_s2 <= minus_s1;
      minus_s3 <= minus_s2;
    end
  end

  // A level changes only once the second and third stages agree
  wire [axes-1:0] plus_agree  = ~(plus_s2 ^ plus_s3);
  wire [axes-1:0] minus_agree = ~(minus_s2 ^ minus_s3);

  always_ff @(posedge clk) begin
    if (!rstn) begin
      plus_level  <= '0;
      minus_level <= '0;
      plus_prev   <= '0;
      minus_prev  <= '0;
    end else begin
      plus_level  <= (plus_agree & plus_s3) | (~plus_agree & plus_level);
      minus_level <= (minus_agree & minus_s3)
                   | (~minus_agree & minus_level);
      plus_prev   <= plus_level;
      minus_prev  <= minus_level;
    end
  end

  genvar i;
  generate
    for (i = 0; i < axes; i++) begin : g_axis
      wire self_clean = (chan_code[i] == axis_fault_pkg::code_none);
      // Partner faults: another member of the group holds a live code
      wire others_interp = |(faulted & interp_member
                             & ~(axes'(1) << i));
      wire others_sync   = |(faulted & sync_member
                             & ~(axes'(1) << i));

      assign faulted[i] = ~self_clean;

      // Servo lock history for the drop-out check
      always_ff @(posedge clk) begin
        if (!rstn)
          lock_prev[i] <= 1'b0;
        else
          lock_prev[i] <= ev[i].servo_locked;
      end

      axis_fault_channel u_chan (
        .clk                  (clk),
        .rstn                 (rstn),
        .ev                   (ev[i]),
        .val                  (val[i]),
        .limit_plus           (plus_level[i]),
        .limit_minus          (minus_level[i]),
        .servo_lock_prev      (lock_prev[i]),
        .limit_plus_prev      (plus_prev[i]),
        .limit_minus_prev     (minus_prev[i]),
        .interp_partner_fault (others_interp & interp_member[i]), // RULE13
        .sync_partner_fault   (others_sync & sync_member[i]), // RULE16
        .all_abnormal_end     (all_abnormal_end), // RULE11
        .clear                (error_clear[i]),
        .code                 (chan_code[i]),
        .stop_axis            (chan_stop[i])
      );

      // Full code is the fixed upper part over the held lower part, or all zero when nothing is held
      always_ff @(posedge clk) begin
        if (!rstn) begin
          error_code[i]       <= axis_fault_pkg::full_code_reset;
          error_present[i]    <= 1'b0;
          stop_request_out[i] <= 1'b0;
        end else begin
          error_code[i]       <= self_clean
                               ? axis_fault_pkg::full_code_reset
                               : {axis_fault_pkg::code_upper,
                                  chan_code[i]}; // RULE1
          error_present[i]    <= ~self_clean;
          stop_request_out[i] <= chan_stop[i];
        end
      end
    end
  endgenerate
endmodule

//--- axis_fault_properties.sv
// Checker for the axis fault monitor, watching axis 0 at the top ports.
// Assumes one clock domain with a synchronous active-low reset.
module axis_fault_properties #(
  parameter int axes = 16
) (
  input wire logic                           clk,
  input wire logic                           rstn,
  input wire axis_fault_pkg::axis_event_type ev [axes],
  input wire logic [axes-1:0]                error_clear,
  input wire logic [31:0]                    error_code [axes],
  input wire logic [axes-1:0]                error_present,
  input wire logic [axes-1:0]                stop_request_out
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  // Code shape and the flags that follow it
  property p_upper;
    error_present[0] |-> error_code[0][31:16] == 16'h00F0;
  endproperty
  a_upper: assert property (p_upper) else $error("upper half wrong");
  property p_present;
    error_present[0] == (error_code[0] != 32'h00000000);
  endproperty
  a_present: assert property (p_present) else $error("present flag off");
  property p_stop;
    stop_request_out[0] == error_present[0];
  endproperty
  a_stop: assert property (p_stop) else $error("stop not with code");
  // Detection two edges after the cause when nothing is held
  property p_start;
    ev[0].start_request && !ev[0].servo_locked && !error_present[0]
      ##1 !error_present[0] |-> ##1 error_code[0] == 32'h00F03000;
  endproperty
  a_start: assert property (p_start) else $error("start not refused");
  property p_lost;
    $past(rstn) && $fell(ev[0].servo_locked) && ev[0].busy &&
      !ev[0].start_request && !error_present[0] ##1 !error_present[0]
      |-> ##1 error_code[0] == 32'h00F03001;
  endproperty
  a_lost: assert property (p_lost) else $error("servo loss missed");
  property p_power;
    ev[0].servo_locked && ev[0].servo_on_request && !ev[0].main_power_on &&
      !error_present[0] ##1 !error_present[0]
      |-> ##1 error_code[0] == 32'h00F03005;
  endproperty
  a_power: assert property (p_power) else $error("power off missed");
  // Code holds until a clear and only a clear removes it
  property p_hold;
    error_present[0] && !$past(error_clear[0]) |=> $stable(error_code[0]);
  endproperty
  a_hold: assert property (p_hold) else $error("code moved");
  property p_fall;
    $past(rstn) && $fell(error_present[0]) |-> $past(error_clear[0], 2);
  endproperty
  a_fall: assert property (p_fall) else $error("code lost");
  c_start: cover property (error_code[0] == 32'h00F03000);
  c_partner: cover property (error_code[0] == 32'h00F03033);
  c_clear: cover property ($fell(error_present[0]));
endmodule

bind axis_fault_monitor axis_fault_properties #(.axes(axes))
  axis_fault_properties_inst (.clk(clk), .rstn(rstn), .ev(ev),
  .error_clear(error_clear), .error_code(error_code),
  .error_present(error_present), .stop_request_out(stop_request_out));

//--- amp_limit_model.sv
// Limit switches of the servo amplifiers, as the bench asks for them.
// Assumes nothing of the unit clock; pins move out of step with it.
module servo_amplifier_limit_model #(
  parameter int axes = 4
) (
  input  wire logic [axes-1:0] want_plus,
  input  wire logic [axes-1:0] want_minus,
  output wire logic [axes-1:0] limit_plus_pin,
  output wire logic [axes-1:0] limit_minus_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  // Switches settle 7 ns after they are asked to move; a continuous
  // assignment with this delay is unknown for the first 7 ns, until the initial request arrives
  assign #7 limit_plus_pin  = want_plus;
  assign #7 limit_minus_pin = want_minus;
endmodule

//--- axis_fault_monitor_tb.sv
// Bench for the axis fault monitor with four axes and a limit model.
// Assumes the checker binds itself; inputs change at the falling edge.
module axis_fault_monitor_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int axes = 4;
  logic                           clk;
  logic                           rstn;
  axis_fault_pkg::axis_event_type ev [axes];
  axis_fault_pkg::axis_value_type val [axes];
  logic [axes-1:0]                want_plus;
  logic [axes-1:0]                want_minus;
  logic [axes-1:0]                limit_plus_pin;
  logic [axes-1:0]                limit_minus_pin;
  logic [axes-1:0]                interp_member;
  logic [axes-1:0]                sync_member;
  logic                           all_abnormal_end;
  logic [axes-1:0]                error_clear;
  logic [31:0]                    error_code [axes];
  logic [axes-1:0]                error_present;
  logic [axes-1:0]                stop_request_out;
  int                             fails;
  int                             n_checks;
  logic [15:0]                    codes [26] = '{
    16'h3000, 16'h3001, 16'h3005, 16'h3012,
    16'h3010, 16'h3011, 16'h3020, 16'h3021,
    16'h3025, 16'h3030, 16'h3031, 16'h3032,
    16'h3033, 16'h3035, 16'h3040, 16'h3043,
    16'h3046, 16'h3050, 16'h3051, 16'h3060,
    16'h3032, 16'h3032, 16'h3040, 16'h3040,
    16'h3031, 16'h3040};

  axis_fault_monitor #(.axes(axes)) axis_fault_monitor_inst (
    .clk(clk), .rstn(rstn), .ev(ev), .val(val),
    .limit_plus_pin(limit_plus_pin), .limit_minus_pin(limit_minus_pin),
    .interp_member(interp_member), .sync_member(sync_member),
    .all_abnormal_end(all_abnormal_end), .error_clear(error_clear),
    .error_code(error_code), .error_present(error_present),
    .stop_request_out(stop_request_out));
  servo_amplifier_limit_model #(.axes(axes))
    servo_amplifier_limit_model_inst (
    .want_plus(want_plus), .want_minus(want_minus),
    .limit_plus_pin(limit_plus_pin), .limit_minus_pin(limit_minus_pin));

  // Unit clock, 25 ns period
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // Compares one value and counts it
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Prints the counts and the verdict, then ends the run
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // Puts axis 0 into the state that raises the k-th code, or back out
  task automatic set_cond(input int k, input logic on);
    ev[0].start_request       = on && k == 0;
    ev[0].servo_locked        = !(on && k inside {0, 1});
    ev[0].busy                = on && k inside {1, 11};
    ev[0].servo_on_request    = on && k == 2;
    ev[0].main_power_on       = !(on && k == 2);
    want_plus[0]              = on && k inside {3, 4};
    want_minus[0]             = on && k inside {3, 5};
    val[0].position           = (on && k == 6) ? 32'h000003E9 :
                                (on && k == 7) ? 32'hFFFFFC17 : 32'h0;
    ev[0].speed_overflow      = on && k == 8;
    ev[0].internal_failure    = on && k == 9;
    all_abnormal_end          = on && k == 10;
    ev[0].abnormal_end        = on && k == 24;
    ev[0].group_change        = on && k inside {11, 20};
    ev[0].stop_request        = on && k inside {20, 25};
    ev[0].group_range_bad     = on && k == 21;
    interp_member             = (on && k == 12) ? 4'h3 : 4'h0;
    ev[0].interp_active       = on && k == 12;
    ev[1].interp_active       = on && k == 12;
    ev[1].internal_failure    = on && k inside {12, 15};
    ev[0].travel_range_bad    = on && k == 13;
    ev[0].sync_group_change   = on && k inside {14, 25};
    ev[0].sync_range_bad      = on && k == 22;
    ev[0].sync_home_fail      = on && k == 23;
    ev[0].sync_active         = on && k inside {14, 15};
    ev[1].sync_active         = on && k == 15;
    sync_member               = (on && k == 15) ? 4'h3 : 4'h0;
    ev[0].move_check_on       = on && k == 16;
    val[0].deviation          = (on && k == 16) ? 32'h00000065 : 32'h64;
    val[0].torque             = (on && k == 17) ? 16'h0065 : 16'h0064;
    val[0].actual_speed       = (on && k == 18) ? 32'h00000065 : 32'h64;
    ev[0].home_not_executable = on && k == 19;
  endtask

  // Calm state on every axis; axis 0 values sit on their thresholds
  task automatic idle;
    for (int a = 0; a < axes; a++) begin
      ev[a] = '0;
      val[a] = '0;
      val[a].soft_upper = 32'h000003E8;
      val[a].soft_lower = 32'hFFFFFC18;
      val[a].deviation_limit = 32'h00000064;
      val[a].torque_limit = 16'h0064;
      val[a].speed_limit = 32'h00000064;
    end
    want_plus = '0;
    want_minus = '0;
    set_cond(0, 1'b0);
    val[0].position = 32'h000003E8;
  endtask

  // Watchdog cuts a hang short
  initial begin
    repeat (3000) @(posedge clk);
    fails++;
    report_and_stop();
  end

  // Main sequence
  initial begin
    rstn = 1'b0;
    error_clear = '0;
    fails = 0;
    n_checks = 0;
    idle();
    repeat (3) @(negedge clk);
    rstn = 1'b1;
    repeat (10) @(negedge clk);
    check(error_code[0], 32'h0);
    $display("threshold test done");
    for (int k = 0; k < 26; k++) begin
      set_cond(k, 1'b1);
      repeat (8) @(negedge clk);
      check(error_code[0], {16'h00F0, codes[k]});
      check({30'h0, stop_request_out[0], error_present[0]}, 32'h3);
      if (k == 10)
        check(error_code[3], 32'h00F03031);
      if (k == 24)
        check(error_code[3], 32'h0);
      if (k inside {12, 15})
        check(error_code[1], 32'h00F03030);
      set_cond(k, 1'b0);
      repeat (3) @(negedge clk);
      check(error_code[0], {16'h00F0, codes[k]});
      error_clear = '1;
      repeat (4) @(negedge clk);
      error_clear = '0;
      repeat (3) @(negedge clk);
      check(error_code[0], 32'h0);
      check({31'h0, error_present[0]}, 32'h0);
      $display("code test %0d done", k);
    end
    // Group changes on a calm axis, deviation over with the check off
    ev[0].group_change      = 1'b1;
    ev[0].sync_group_change = 1'b1;
    val[0].deviation        = 32'h00000065;
    repeat (8) @(negedge clk);
    check(error_code[0], 32'h0);
    set_cond(0, 1'b0);
    repeat (3) @(negedge clk);
    $display("calm change test done");
    // First code is kept; a level cause left at the clear reloads
    set_cond(0, 1'b1);
    repeat (8) @(negedge clk);
    val[0].torque = 16'h0065;
    repeat (4) @(negedge clk);
    check(error_code[0], 32'h00F03000);
    ev[0].start_request = 1'b0;
    ev[0].servo_locked  = 1'b1;
    error_clear = '1;
    repeat (4) @(negedge clk);
    error_clear = '0;
    repeat (3) @(negedge clk);
    check(error_code[0], 32'h00F03050);
    val[0].torque = 16'h0064;
    error_clear = '1;
    repeat (4) @(negedge clk);
    error_clear = '0;
    repeat (3) @(negedge clk);
    check(error_code[0], 32'h0);
    $display("held code test done");
    report_and_stop();
  end
endmodule
